// file: rtl/apc_pkg.sv
// package: register map, fields and reset values of the host register set
// How it works
// - offset zero reports running image code
// - offset one reports minor or loader revision
// - only 0xe0 and above until processor ready
// - only firmware sets processor-ready flag
// - boot selection encodes loader, nosleep, ram
// - boot selection kept in always-on domain
// - boot selection read by firmware and by host at 0xe0
// - writing one from zero starts oscillator, wakes
// - loader resets, application idles on wake
// - writing zero requests standby interrupt
// - firmware powers down, then stops oscillator
package apc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] APC_OFS_IMAGE_CODE = 8'h00;
  localparam logic [7:0] APC_OFS_IMAGE_REV  = 8'h01;
  localparam logic [7:0] APC_OFS_POWER_CTL  = 8'he0;
  localparam logic [7:0] APC_OFS_ALWAYS_MIN = 8'he0;
  // ==========================================================
  // image codes
  localparam logic [7:0] APC_CODE_APP    = 8'h03;
  localparam logic [7:0] APC_CODE_LOADER = 8'h80;
  localparam logic [7:0] APC_CODE_RESET  = 8'h00;
  localparam logic [7:0] APC_REV_RESET   = 8'h00;
  // ==========================================================
  // power control fields
  localparam int APC_BIT_READY   = 6;
  localparam int APC_BIT_SEL_HI  = 5;
  localparam int APC_BIT_SEL_LO  = 4;
  localparam int APC_BIT_PON     = 0;
  localparam logic       APC_PON_RESET = 1'b1;
  localparam logic [1:0] APC_SEL_RESET = 2'h0;
  // boot selections
  localparam logic [1:0] APC_SEL_LOADER  = 2'h0;
  localparam logic [1:0] APC_SEL_NOSLEEP = 2'h1;
  localparam logic [1:0] APC_SEL_RAM     = 2'h2;
  localparam logic [1:0] APC_SEL_RSVD    = 2'h3;
  // ==========================================================
  // host timing
  localparam int APC_CLK_HZ         = 20_000_000;
  localparam int APC_REMAP_WAIT_MS  = 6;
  localparam int APC_REMAP_WAIT_CYC =
    APC_REMAP_WAIT_MS * (APC_CLK_HZ / 1000);
endpackage

// file: rtl/apc_regs.sv
// module: image id registers, reachable once ready, and always-reachable power control register
`timescale 1ns/10ps
module apc_regs
  import apc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // host register port
  input  wire logic [7:0] host_addr,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  input  wire logic [7:0] host_wdata,
  output logic      [7:0] host_rdata,
  output logic            host_rvalid,
  output logic            host_mapped_req,
  // firmware side
  input  wire logic       fw_ready_set,
  input  wire logic       fw_ready_clr,
  input  wire logic       fw_id_load,
  input  wire logic [7:0] fw_image_code,
  input  wire logic [7:0] fw_image_rev,
  input  wire logic       fw_osc_stop,
  // power and processor events
  output logic            osc_en,
  output logic            wake_interrupt,
  output logic            standby_interrupt,
  output logic      [1:0] boot_select
);
  // ==========================================================
  // state
  logic [7:0] code_reg;
  logic [7:0] rev_reg;
  logic       ready_reg;
  logic [1:0] sel_reg;
  logic       pon_reg;
  logic       osc_reg;
  logic       wake_reg;
  logic       stby_reg;
  logic [7:0] rdata_reg;
  logic       rvalid_reg;
  logic       ready_next;
  logic [7:0] rdata_next;

  // ==========================================================
  // decode
  wire        hit_code  = host_addr == APC_OFS_IMAGE_CODE;
  wire        hit_rev   = host_addr == APC_OFS_IMAGE_REV;
  wire        hit_pctl  = host_addr == APC_OFS_POWER_CTL;
  wire        always_ok = host_addr >= APC_OFS_ALWAYS_MIN;
  wire        space_ok  = always_ok || ready_reg;
  wire        wr_pctl   = host_wr && hit_pctl;
  wire        pon_rise  = wr_pctl && !pon_reg &&
                          host_wdata[APC_BIT_PON];
  wire        pon_fall  = wr_pctl && !host_wdata[APC_BIT_PON];
  wire [7:0]  pctl_view = {1'b0, ready_reg, sel_reg,
                           3'h0, pon_reg};
  // image code and revision come only from firmware load
  wire [7:0]  mapped_view = hit_code ? code_reg :
                            hit_rev  ? rev_reg  : 8'h00;

  // ready flag: no hardware path, firmware only
  assign ready_next = fw_ready_set ? 1'b1 :
                      fw_ready_clr ? 1'b0 : ready_reg;

  assign rdata_next = !space_ok ? 8'h00 :
                      hit_pctl  ? pctl_view : mapped_view;

  // ==========================================================
  // identification
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      code_reg <= APC_CODE_RESET;
      rev_reg  <= APC_REV_RESET;
    end else if (fw_id_load) begin
      code_reg <= fw_image_code;
      rev_reg  <= fw_image_rev;
    end
  end

  // ==========================================================
  // power control
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ready_reg <= 1'b0;
      pon_reg   <= APC_PON_RESET;
    end else begin
      ready_reg <= ready_next;
      if (wr_pctl) begin
        pon_reg <= host_wdata[APC_BIT_PON];
      end
    end
  end

  // boot selection sits in the always-on domain, only rst clears it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_reg <= APC_SEL_RESET;
    end else if (wr_pctl) begin
      sel_reg <= host_wdata[APC_BIT_SEL_HI:APC_BIT_SEL_LO];
    end
  end

  // oscillator: started by hardware, stopped only by firmware
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_reg <= 1'b1;
    end else if (pon_rise) begin
      osc_reg <= 1'b1;
    end else if (fw_osc_stop) begin
      osc_reg <= 1'b0;
    end
  end

  // processor event pulses
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_reg <= 1'b0;
      stby_reg <= 1'b0;
    end else begin
      wake_reg <= pon_rise;
      stby_reg <= pon_fall;
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= host_rd;
      if (host_rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign host_rdata        = rdata_reg;
  assign host_rvalid       = rvalid_reg;
  assign host_mapped_req   = (host_rd || host_wr) && !always_ok &&
                             ready_reg;
  assign osc_en            = osc_reg;
  assign wake_interrupt    = wake_reg;
  assign standby_interrupt = stby_reg;
  assign boot_select       = sel_reg;
endmodule

// file: tb/apc_host.sv
// partner: host processor making single byte register accesses
`timescale 1ns/10ps
module apc_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] host_rdata,
  input  wire logic       host_mapped_req,
  output logic      [7:0] host_addr, host_wdata,
  output logic            host_wr, host_rd
);
  logic mapped_seen;
  initial begin
    mapped_seen = 1'b0;
    host_addr = 8'he0;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge core_clk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge core_clk);
    mapped_seen = host_mapped_req;
    host_rd <= 1'b0;
    #1;
    d = host_rdata;
  endtask
endmodule

// file: tb/apc_regs_monitor.sv
// checker: port rules of the image id and power control registers
`timescale 1ns/10ps
module apc_regs_monitor
  import apc_pkg::*;
(
  input wire logic       core_clk, rst, host_wr, host_rd, host_rvalid,
  input wire logic       host_mapped_req, fw_osc_stop, osc_en,
  input wire logic       wake_interrupt, standby_interrupt,
  input wire logic [7:0] host_addr, host_wdata, host_rdata,
  input wire logic [1:0] boot_select
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic pc_wr = host_wr && host_addr == APC_OFS_POWER_CTL;
  chk_read_answer: assert property (host_rd |=> host_rvalid)
    else $error("read unanswered");
  chk_gate_read: assert property (
    host_rd && host_addr < APC_OFS_ALWAYS_MIN && !host_mapped_req
    |=> host_rdata == 8'h00) else $error("gated read not zero");
  chk_rsvd_zero: assert property (host_rd && host_addr == 8'he0
    |=> !host_rdata[7] && host_rdata[3:1] == 3'h0) else $error("rsvd set");
  chk_wake_cause: assert property (wake_interrupt
    |-> $past(pc_wr) && $past(host_wdata[0])) else $error("stray wake");
  chk_wake_osc: assert property (wake_interrupt |-> osc_en)
    else $error("wake without osc");
  chk_stby_req: assert property (pc_wr && !host_wdata[0]
    |=> standby_interrupt) else $error("no standby request");
  chk_osc_kept: assert property (
    pc_wr && !host_wdata[0] && osc_en && !fw_osc_stop |=> osc_en)
    else $error("osc stopped by host");
  chk_sel_load: assert property (
    pc_wr |=> boot_select == $past(host_wdata[5:4])) else $error("sel");
  chk_sel_hold: assert property (!pc_wr |=> $stable(boot_select))
    else $error("sel changed");
  cover property (wake_interrupt);
  cover property (standby_interrupt);
  cover property (fw_osc_stop ##1 !osc_en);
endmodule
bind apc_regs apc_regs_monitor u_mon (.core_clk, .rst, .host_wr, .host_rd,
  .host_rvalid, .host_mapped_req, .fw_osc_stop, .osc_en, .wake_interrupt,
  .standby_interrupt, .host_addr, .host_wdata, .host_rdata, .boot_select);

// file: tb/apc_regs_tb.sv
// testbench: image id and power control scenarios
`timescale 1ns/10ps
module apc_regs_tb;
  import apc_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, fw_ready_set = 1'b0, fw_ready_clr = 1'b0;
  logic fw_id_load = 1'b0, fw_osc_stop = 1'b0, host_wr, host_rd;
  logic host_rvalid, host_mapped_req, osc_en, wake_interrupt, standby_interrupt;
  logic [7:0] fw_image_code = 8'h00, fw_image_rev = 8'h00, d;
  logic [7:0] host_addr, host_wdata, host_rdata;
  logic [1:0] boot_select;
  int fail_count = 0, comparisons = 0, cyc = 0;
  always #25 core_clk = ~core_clk;
  apc_host u_apc_host (.core_clk, .host_rdata, .host_mapped_req,
    .host_addr, .host_wdata, .host_wr, .host_rd);
  apc_regs u_apc_regs (.*);
  task automatic cmp(input string n, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic fw_id(input logic [7:0] c, r);
    @(posedge core_clk);
    fw_id_load <= 1'b1;
    fw_image_code <= c;
    fw_image_rev <= r;
    @(posedge core_clk);
    fw_id_load <= 1'b0;
  endtask
  task automatic t_ids;
    u_apc_host.rd(8'he0, d); cmp("pwr", 8'h01, d);
    fw_id(8'h03, 8'h07);
    u_apc_host.rd(8'h00, d); cmp("gated", 8'h00, d);
    cmp("rvalid", 8'h01, {7'h00, host_rvalid});
    cmp("unmapped", 8'h00, {7'h00, u_apc_host.mapped_seen});
    @(posedge core_clk);
    fw_ready_set <= 1'b1;
    u_apc_host.rd(8'he0, d); cmp("ready", 8'h41, d);
    u_apc_host.rd(8'h00, d); cmp("code", 8'h03, d);
    cmp("mapped", 8'h01, {7'h00, u_apc_host.mapped_seen});
    u_apc_host.rd(8'h01, d); cmp("rev", 8'h07, d);
    fw_id(8'h80, 8'h02);
    u_apc_host.rd(8'h00, d); cmp("loader", 8'h80, d);
    $display("test ids done");
  endtask
  task automatic t_power;
    u_apc_host.wr(8'he0, 8'h20);
    cmp("stby", 8'h01, {7'h00, standby_interrupt});
    cmp("osc kept", 8'h01, {7'h00, osc_en});
    @(posedge core_clk);
    fw_osc_stop <= 1'b1;
    @(posedge core_clk);
    fw_osc_stop <= 1'b0;
    @(posedge core_clk);
    cmp("osc off", 8'h00, {7'h00, osc_en});
    u_apc_host.wr(8'he0, 8'h21);
    cmp("wake", 8'h01, {7'h00, wake_interrupt});
    cmp("osc on", 8'h01, {7'h00, osc_en});
    cmp("sel", 8'h02, {6'h00, boot_select});
    @(posedge core_clk);
    fw_ready_set <= 1'b0;
    fw_ready_clr <= 1'b1;
    u_apc_host.wr(8'he0, 8'hff);
    cmp("no wake", 8'h00, {7'h00, wake_interrupt});
    u_apc_host.rd(8'he0, d); cmp("pwr ro", 8'h31, d);
    $display("test power done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 400) begin
      fail_count++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_ids;
    t_power;
    tally_and_finish;
  end
endmodule
